// >>> ovs_pkg.sv
// package for the otg vbus status and switch control block
package ovs_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    // session end threshold in millivolts, compared outside in analog
    localparam int unsigned SESS_END_MV = 500;
    // status bit positions in the comparator status word
    localparam int unsigned STS_VBUS_VLD_BIT = 1;
    localparam int unsigned STS_SESS_VLD_BIT = 2;
    localparam int unsigned STS_SESS_END_BIT = 3;
    localparam logic [4:0] STS_RST = 5'h00;
    localparam logic [1:0] REG_LVL_RST = 2'h0;
    localparam logic [2:0] CMP_RST = 3'h0;
    // reset values of control outputs
    localparam logic SWITCH_RST = 1'b1;
    localparam logic PULLUP_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [1:0] LS_RST = 2'h0;
    // receivers start off because both audio switches are closed in reset
    localparam logic SE_RX_RST = 1'b0;
    localparam logic EXT_IND_LEVEL = 1'b1;
    // comparator index order
    localparam int unsigned CMP_SESS_END = 0;
    localparam int unsigned CMP_SESS_VLD = 1;
    localparam int unsigned CMP_VBUS_VLD = 2;
    localparam int unsigned NUM_CMP = 3;
    typedef enum logic [1:0] {
        OVS_MODE_SYNC,
        OVS_MODE_UART_ENTER,
        OVS_MODE_UART
    } ovs_mode_e;
endpackage : ovs_pkg

// >>> ovs_cmp_if.sv
// interface carrying comparator events between detector and top
`timescale 1ns/1ps
interface ovs_cmp_if;
    logic [2:0] level;
    logic [2:0] rise;
    logic [2:0] fall;
    modport det (output level, output rise, output fall);
    modport use_side (input level, input rise, input fall);
endinterface : ovs_cmp_if

// >>> ovs_cmp_det.sv
// synchroniser and edge detector for the three vbus comparators
`timescale 1ns/1ps
module ovs_cmp_det (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [2:0] cmp_raw_i,
    ovs_cmp_if.det cmp
);
    import ovs_pkg::*;
    logic [2:0] meta_q, meta_d;
    logic [2:0] sync_q, sync_d;
    logic [2:0] prev_q, prev_d;
    logic [2:0] rise_q, rise_d;
    logic [2:0] fall_q, fall_d;

    always_comb begin
        meta_d = cmp_raw_i;
        sync_d = meta_q;
        prev_d = sync_q;
        rise_d = sync_q & ~prev_q;
        fall_d = ~sync_q & prev_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            meta_q <= CMP_RST;
            sync_q <= CMP_RST;
            prev_q <= CMP_RST;
            rise_q <= CMP_RST;
            fall_q <= CMP_RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign cmp.level = prev_q;
    assign cmp.rise = rise_q;
    assign cmp.fall = fall_q;
endmodule : ovs_cmp_det

// >>> ovs_ctrl.sv
// top of the otg vbus status, pulsing and switch control block
`timescale 1ns/1ps
module ovs_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [2:0] cmp_raw_i,
    input wire logic [4:0] int_en_rise_i,
    input wire logic [4:0] int_en_fall_i,
    input wire logic use_ext_ind_i,
    input wire logic ind_passthru_i,
    input wire logic ind_complement_i,
    input wire logic bus_power_discharge_en_i,
    input wire logic bus_power_charge_en_i,
    input wire logic uart_mode_req_i,
    input wire logic [1:0] serial_mode_regulator_level_i,
    input wire logic [1:0] sync_regulator_level_i,
    input wire logic [1:0] line_state_i,
    input wire logic charger_pullup_dp_en_i,
    input wire logic charger_pullup_dm_en_i,
    input wire logic left_audio_switch_en_i,
    input wire logic right_audio_switch_en_i,
    input wire logic microphone_switch_en_i,
    output logic [4:0] int_status_o,
    output logic rx_vbus_valid_o,
    output logic int_event_o,
    output logic discharge_pulldown_o,
    output logic charge_pullup_o,
    output logic [1:0] regulator_level_o,
    output logic uart_active_o,
    output logic [1:0] line_state_o,
    output logic line_state_valid_o,
    output logic dp_pullup_o,
    output logic dm_pullup_o,
    output logic dp_audio_switch_o,
    output logic dm_audio_switch_o,
    output logic se_rx_enable_o
);
    import ovs_pkg::*;

    ovs_cmp_if cmp_bus ();

    ovs_cmp_det u_det (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .cmp_raw_i(cmp_raw_i),
        .cmp(cmp_bus.det)
    );

    // enable bit position of each comparator in the enable words
    localparam int unsigned EN_POS [NUM_CMP] = '{STS_SESS_END_BIT, STS_SESS_VLD_BIT,
                                                 STS_VBUS_VLD_BIT};

    logic [2:0] cmp_on;
    logic [2:0] shown;
    logic [2:0] evt;

    // session valid stays powered even when both enables are clear
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            if (g == CMP_SESS_VLD) begin : g_keep
                assign cmp_on[g] = 1'b1;
            end else begin : g_gate
                assign cmp_on[g] = int_en_rise_i[EN_POS[g]] | int_en_fall_i[EN_POS[g]];
            end
            // disabled comparator reads 0
            assign shown[g] = cmp_bus.level[g] & cmp_on[g];
            assign evt[g] = (cmp_bus.rise[g] & int_en_rise_i[EN_POS[g]])
                          | (cmp_bus.fall[g] & int_en_fall_i[EN_POS[g]]);
        end
    endgenerate

    logic [4:0] sts_q, sts_d;
    logic rxv_q, rxv_d;
    logic evt_q, evt_d;
    logic ext_ind;

    // no pin brings an external indicator in, so it reads as one
    assign ext_ind = EXT_IND_LEVEL;

    always_comb begin
        sts_d = STS_RST;
        sts_d[STS_SESS_END_BIT] = shown[CMP_SESS_END];
        sts_d[STS_SESS_VLD_BIT] = shown[CMP_SESS_VLD];
        sts_d[STS_VBUS_VLD_BIT] = shown[CMP_VBUS_VLD];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sts_q <= STS_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    // vbus valid handed to the receive command path
    always_comb begin
        if (!use_ext_ind_i) begin
            rxv_d = shown[CMP_VBUS_VLD];
        end else if (ind_passthru_i) begin
            rxv_d = ext_ind ^ ind_complement_i;
        end else begin
            // non-passthru qualifies internal comparator with indicator
            rxv_d = (ext_ind ^ ind_complement_i) & shown[CMP_VBUS_VLD];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rxv_q <= FLAG_RST;
        end else begin
            rxv_q <= rxv_d;
        end
    end

    // one pulse per cycle with any enabled edge, the link turns it into a command
    always_comb begin
        evt_d = |evt;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            evt_q <= FLAG_RST;
        end else begin
            evt_q <= evt_d;
        end
    end

    // uart mode tracking and regulator selection
    ovs_mode_e mode_q, mode_d;
    logic [1:0] reg_q, reg_d;
    logic uart_q, uart_d;
    logic [1:0] ls_q, ls_d;
    logic lsv_q, lsv_d;

    // regulator switches one cycle after the mode flag rises
    always_comb begin
        mode_d = mode_q;
        reg_d = reg_q;
        case (mode_q)
            OVS_MODE_SYNC: begin
                reg_d = sync_regulator_level_i;
                if (uart_mode_req_i) begin
                    mode_d = OVS_MODE_UART_ENTER;
                end
            end
            OVS_MODE_UART_ENTER: begin
                reg_d = serial_mode_regulator_level_i;
                mode_d = uart_mode_req_i ? OVS_MODE_UART : OVS_MODE_SYNC;
            end
            OVS_MODE_UART: begin
                reg_d = serial_mode_regulator_level_i;
                if (!uart_mode_req_i) begin
                    mode_d = OVS_MODE_SYNC;
                end
            end
            default: begin
                mode_d = OVS_MODE_SYNC;
                reg_d = REG_LVL_RST;
            end
        endcase
        uart_d = (mode_d != OVS_MODE_SYNC);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            mode_q <= OVS_MODE_SYNC;
            reg_q <= REG_LVL_RST;
            uart_q <= FLAG_RST;
        end else begin
            mode_q <= mode_d;
            reg_q <= reg_d;
            uart_q <= uart_d;
        end
    end

    // line state hidden once uart takes the data lines
    always_comb begin
        if (mode_d == OVS_MODE_SYNC) begin
            ls_d = line_state_i;
            lsv_d = 1'b1;
        end else begin
            ls_d = 2'h0;
            lsv_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ls_q <= LS_RST;
            lsv_q <= FLAG_RST;
        end else begin
            ls_q <= ls_d;
            lsv_q <= lsv_d;
        end
    end

    // vbus pulsing resistors, both open out of reset
    logic dis_q, dis_d;
    logic chg_q, chg_d;

    always_comb begin
        dis_d = bus_power_discharge_en_i;
        chg_d = bus_power_charge_en_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            dis_q <= FLAG_RST;
            chg_q <= FLAG_RST;
        end else begin
            dis_q <= dis_d;
            chg_q <= chg_d;
        end
    end

    // charger detection pull-ups
    logic dpp_q, dpp_d;
    logic dmp_q, dmp_d;

    always_comb begin
        dpp_d = charger_pullup_dp_en_i;
        dmp_d = charger_pullup_dm_en_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            dpp_q <= PULLUP_RST;
            dmp_q <= PULLUP_RST;
        end else begin
            dpp_q <= dpp_d;
            dmp_q <= dmp_d;
        end
    end

    // audio switches close in reset so audio passes while the phy is held
    logic dps_q, dps_d;
    logic dms_q, dms_d;

    always_comb begin
        dps_d = left_audio_switch_en_i;
        dms_d = right_audio_switch_en_i | microphone_switch_en_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            dps_q <= SWITCH_RST;
            dms_q <= SWITCH_RST;
        end else begin
            dps_q <= dps_d;
            dms_q <= dms_d;
        end
    end

    // single-ended receivers would read audio swing as line activity
    logic se_q, se_d;

    always_comb begin
        se_d = ~(dps_d | dms_d);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            se_q <= SE_RX_RST;
        end else begin
            se_q <= se_d;
        end
    end

    assign int_status_o = sts_q;
    assign rx_vbus_valid_o = rxv_q;
    assign int_event_o = evt_q;
    assign discharge_pulldown_o = dis_q;
    assign charge_pullup_o = chg_q;
    assign regulator_level_o = reg_q;
    assign uart_active_o = uart_q;
    assign line_state_o = ls_q;
    assign line_state_valid_o = lsv_q;
    assign dp_pullup_o = dpp_q;
    assign dm_pullup_o = dmp_q;
    assign dp_audio_switch_o = dps_q;
    assign dm_audio_switch_o = dms_q;
    assign se_rx_enable_o = se_q;
endmodule : ovs_ctrl

// >>> ovs_ctrl_assertions.sv
// concurrent checks on the ports of the vbus status and switch block
`timescale 1ns/1ps
module ovs_ctrl_chk (
    input logic clk_sys_i,
    input logic rst_b_i,
    input logic [4:0] int_en_rise_i,
    input logic [4:0] int_en_fall_i,
    input logic use_ext_ind_i,
    input logic ind_passthru_i,
    input logic ind_complement_i,
    input logic bus_power_discharge_en_i,
    input logic bus_power_charge_en_i,
    input logic charger_pullup_dp_en_i,
    input logic charger_pullup_dm_en_i,
    input logic left_audio_switch_en_i,
    input logic right_audio_switch_en_i,
    input logic microphone_switch_en_i,
    input logic [4:0] int_status_o,
    input logic rx_vbus_valid_o,
    input logic discharge_pulldown_o,
    input logic charge_pullup_o,
    input logic uart_active_o,
    input logic [1:0] line_state_o,
    input logic dp_pullup_o,
    input logic dm_pullup_o,
    input logic dp_audio_switch_o,
    input logic dm_audio_switch_o,
    input logic se_rx_enable_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // reset values only show once an edge has seen reset low
    property p_rst;
        disable iff (1'b0) !rst_b_i ##1 !rst_b_i |-> dp_audio_switch_o && dm_audio_switch_o
            && !dp_pullup_o && !dm_pullup_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_dis;
        rst_b_i |=> discharge_pulldown_o == $past(bus_power_discharge_en_i);
    endproperty
    a_dis: assert property (p_dis) else $error("discharge wrong");
    property p_chg;
        rst_b_i |=> charge_pullup_o == $past(bus_power_charge_en_i);
    endproperty
    a_chg: assert property (p_chg) else $error("charge wrong");
    property p_pull;
        rst_b_i |=> {dp_pullup_o, dm_pullup_o} ==
            $past({charger_pullup_dp_en_i, charger_pullup_dm_en_i});
    endproperty
    a_pull: assert property (p_pull) else $error("pullup wrong");
    property p_aud;
        rst_b_i |=> dp_audio_switch_o == $past(left_audio_switch_en_i) && dm_audio_switch_o
            == $past(right_audio_switch_en_i || microphone_switch_en_i);
    endproperty
    a_aud: assert property (p_aud) else $error("audio switch wrong");
    property p_serx;
        dp_audio_switch_o || dm_audio_switch_o |-> !se_rx_enable_o;
    endproperty
    a_serx: assert property (p_serx) else $error("receivers on");
    property p_line;
        uart_active_o |-> line_state_o == 2'h0;
    endproperty
    a_line: assert property (p_line) else $error("line state in uart");
    property p_off;
        !int_en_rise_i[1] && !int_en_fall_i[1] |=> !int_status_o[1];
    endproperty
    a_off: assert property (p_off) else $error("vbus status not off");
    property p_pass;
        use_ext_ind_i && ind_passthru_i |=> rx_vbus_valid_o == !$past(ind_complement_i);
    endproperty
    a_pass: assert property (p_pass) else $error("fixed indicator wrong");
endmodule : ovs_ctrl_chk
bind ovs_ctrl ovs_ctrl_chk i_ovs_ctrl_chk (.*);

// >>> ovs_link_model.sv
// link side model: counts events and tracks the session
`timescale 1ns/1ps
module ovs_link_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic int_event_o,
    input wire logic [4:0] int_status_o,
    output logic [3:0] evt_cnt_o,
    output logic session_up_o
);
    // session from session valid, not vbus valid, whose threshold is higher
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            evt_cnt_o <= 4'h0;
        end else begin
            evt_cnt_o <= evt_cnt_o + {3'h0, int_event_o};
        end
        session_up_o <= int_status_o[2];
    end
endmodule : ovs_link_model

// >>> ovs_ctrl_bench.sv
// self checking bench for the vbus status and switch block
`timescale 1ns/1ps
module ovs_ctrl_bench;
    logic clk_sys_i = 0, rst_b_i = 0, use_ext_ind_i = 0, ind_passthru_i = 0;
    logic ind_complement_i = 0, bus_power_discharge_en_i = 0, bus_power_charge_en_i = 0;
    logic uart_mode_req_i = 0, charger_pullup_dp_en_i = 1, charger_pullup_dm_en_i = 1;
    logic left_audio_switch_en_i = 0, right_audio_switch_en_i = 0, microphone_switch_en_i = 0;
    logic [2:0] cmp_raw_i = 3'h0;
    logic [4:0] int_en_rise_i = 5'h00, int_en_fall_i = 5'h00, int_status_o;
    logic [1:0] serial_mode_regulator_level_i = 2'h3, sync_regulator_level_i = 2'h1;
    logic [1:0] line_state_i = 2'h2, regulator_level_o, line_state_o;
    logic rx_vbus_valid_o, int_event_o, discharge_pulldown_o, charge_pullup_o, uart_active_o;
    logic line_state_valid_o, dp_pullup_o, dm_pullup_o, dp_audio_switch_o, dm_audio_switch_o;
    logic se_rx_enable_o, session_up_o;
    logic [3:0] evt_cnt_o;
    int mismatches = 0, tests_run = 0;
    `define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
        $display("unexpected %s exp %h got %h", n, e, a); end end
    ovs_ctrl i_ovs_ctrl (.*);
    ovs_link_model i_ovs_link_model (.*);
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : step
    task stop_test;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        step(8);
        `CHK("reset pullups", 2'h0, {dp_pullup_o, dm_pullup_o})
        `CHK("reset switches", 2'h3, {dp_audio_switch_o, dm_audio_switch_o})
        rst_b_i = 1;
        step(1);
        `CHK("pullups", 2'h3, {dp_pullup_o, dm_pullup_o})
        `CHK("switch default", 2'h0, {dp_audio_switch_o, dm_audio_switch_o})
        for (int i = 0; i < 8; i++) begin
            {left_audio_switch_en_i, right_audio_switch_en_i, microphone_switch_en_i} = i[2:0];
            {bus_power_discharge_en_i, bus_power_charge_en_i} = i[1:0];
            step(1);
            `CHK("dp switch", i[2], dp_audio_switch_o)
            `CHK("dm switch", |i[1:0], dm_audio_switch_o)
            `CHK("se rx", i == 0, se_rx_enable_o)
            `CHK("pulsing", i[1:0], {discharge_pulldown_o, charge_pullup_o})
        end
        int_en_rise_i = 5'h0E;
        int_en_fall_i = 5'h0E;
        for (int b = 2; b >= 0; b--) begin
            cmp_raw_i[b] = 1'b1;
            step(6);
        end
        `CHK("status", 5'h0E, int_status_o)
        `CHK("events", 4'h3, evt_cnt_o)
        `CHK("rx vbus internal", 1'b1, rx_vbus_valid_o)
        `CHK("session up", 1'b1, session_up_o)
        for (int i = 0; i < 4; i++) begin
            {use_ext_ind_i, ind_passthru_i, ind_complement_i} = {1'b1, i[1:0]};
            step(1);
            if (i[1]) `CHK("rx vbus fixed", !i[0], rx_vbus_valid_o)
            else `CHK("rx vbus qualified", !i[0], rx_vbus_valid_o)
            use_ext_ind_i = 0;
            step(1);
            `CHK("rx vbus int", 1'b1, rx_vbus_valid_o)
        end
        for (int b = 3; b > 0; b--) begin
            int_en_rise_i[b] = 1'b0;
            int_en_fall_i[b] = 1'b0;
            step(1);
        end
        `CHK("status off", 5'h04, int_status_o)
        `CHK("rx vbus off", 1'b0, rx_vbus_valid_o)
        cmp_raw_i[1] = 1'b0;
        step(6);
        `CHK("sess vld low", 5'h00, int_status_o)
        `CHK("masked events", 4'h3, evt_cnt_o)
        `CHK("session down", 1'b0, session_up_o)
        int_en_fall_i[2] = 1'b1;
        cmp_raw_i[1] = 1'b1;
        step(6);
        cmp_raw_i[1] = 1'b0;
        step(6);
        `CHK("fall event", 4'h4, evt_cnt_o)
        `CHK("line sync", 2'h2, line_state_o)
        `CHK("line valid", 1'b1, line_state_valid_o)
        uart_mode_req_i = 1;
        step(2);
        `CHK("uart line", 3'h4, {uart_active_o, line_state_o})
        `CHK("uart line valid", 1'b0, line_state_valid_o)
        `CHK("uart level", 2'h3, regulator_level_o)
        uart_mode_req_i = 0;
        step(2);
        `CHK("sync level", 2'h1, regulator_level_o)
        stop_test();
    end
endmodule : ovs_ctrl_bench
